// >>> core/acc_defs.svh
/*
 Comparator control constants: register offsets, bit positions, reset values.
 Assumes inclusion by bare name from design files.
*/
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

`define ACC_OFF_CONV_B      8'h00
`define ACC_OFF_CTRL        8'h04
`define ACC_OFF_PIN_DIS     8'h08
`define ACC_OFF_CONV_A      8'h0C
`define ACC_OFF_CHAN_SEL    8'h10

`define ACC_BIT_MUX_BORROW  6
`define ACC_BIT_DISABLE     7
`define ACC_BIT_BANDGAP     6
`define ACC_BIT_OUT         5
`define ACC_BIT_FLAG        4
`define ACC_BIT_IE          3
`define ACC_BIT_CAPTURE     2
`define ACC_BIT_CONV_EN     7

`define ACC_RST_CTRL        8'h00
`define ACC_RST_CONV_B      8'h00
`define ACC_RST_PIN_DIS     2'h0
`define ACC_RST_CONV_A      8'h00
`define ACC_RST_CHAN_SEL    3'h0

`endif

// >>> core/acc_pkg.sv
/*
 Comparator control types.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package acc_pkg;
    typedef enum logic [1:0] {
        ACC_MODE_TOGGLE = 2'h0,
        ACC_MODE_RSVD   = 2'h1,
        ACC_MODE_FALL   = 2'h2,
        ACC_MODE_RISE   = 2'h3
    } acc_mode_t;
endpackage

// >>> core/acc_sync.sv
/*
 Two-flop synchroniser for the comparator output.
 Assumes an asynchronous input and a single clock.
*/
`timescale 1ns/1ps
module acc_sync (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_r;
    logic sync_r;

    // First flop feeds only the second
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule // acc_sync

// >>> core/acc_core.sv
/*
 Comparator control logic with an AHB-Lite register slave.
 Assumes analog core, pins and timer front end outside; one clock hclk.
*/
// Operation
// R1: Borrow on, converter off: channel selects negative
// R2: Otherwise negative pin feeds negative input
// R3: Borrow bit is bit 6 of control B
// R4: Disable bit 7 powers comparator down
// R5: Software masks interrupt before toggling disable
// R6: Bandgap bit 6 selects positive reference
// R7: Output synchronised, one to two cycles
// R8: Selected output event sets flag bit 4
// R9: Request needs flag, enable, global enable
// R10: Vector taken clears the flag
// R11: Writing one clears flag, zero keeps
// R12: Enable bit 3 gates the interrupt
// R13: Capture bit 2 routes output to timer
// R14: Capture bit clear disconnects timer input
// R15: Software sets timer capture enable too
// R16: Mode: toggle, reserved, falling, rising
// R17: Software masks interrupt before mode change
// R18: Input disable bits gate pin buffers
// R19: Software disables unused digital buffers
// R20: Converter on only while enable set
// R21: Edges from current and previous samples
// R22: Upper disable bits read zero
`timescale 1ns/1ps
`include "acc_defs.svh"
module acc_core #(
    parameter int CHANNELS = 8
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        comparator_raw,
    input  wire logic        global_int_enable,
    input  wire logic        vector_taken,
    input  wire logic [1:0]  pin_digital_in,
    output logic             comparator_power_off,
    output logic             positive_use_bandgap,
    output logic             negative_use_channel,
    output logic      [2:0]  negative_channel,
    output logic             timer_capture_in,
    output logic             timer_capture_sel,
    output logic             comparator_irq,
    output logic      [1:0]  pin_buffer_enable,
    output logic      [1:0]  pin_digital_value
);
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] conv_b_r, conv_b_nxt;
    logic [7:0] conv_a_r, conv_a_nxt;
    logic [2:0] chan_r, chan_nxt;
    logic [1:0] pin_dis_r, pin_dis_nxt;
    logic       flag_r, flag_nxt;
    logic       prev_r, prev_nxt;
    logic       wr_pend_r, wr_pend_nxt;
    logic [7:0] wr_addr_r, wr_addr_nxt;
    logic [31:0] hrdata_nxt;
    logic       cmp_sync;
    logic       evt;
    logic       wr_go;
    logic       rd_go;
    logic       converter_on;
    acc_pkg::acc_mode_t mode;

    function automatic logic edge_hit(input acc_pkg::acc_mode_t m,
                                      input logic cur, input logic prv);
        unique case (m)
            acc_pkg::ACC_MODE_TOGGLE: edge_hit = cur ^ prv;
            acc_pkg::ACC_MODE_RSVD:   edge_hit = 1'b0;
            acc_pkg::ACC_MODE_FALL:   edge_hit = prv & ~cur;
            acc_pkg::ACC_MODE_RISE:   edge_hit = cur & ~prv;
        endcase
    endfunction

    acc_sync u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (comparator_raw),
        .sync_out (cmp_sync)
    ); // [R7]

    assign mode  = acc_pkg::acc_mode_t'(ctrl_r[1:0]);
    assign evt   = edge_hit(mode, cmp_sync, prev_r); // [R16] [R21]
    assign wr_go = hsel & hready & htrans[1] & hwrite;
    assign rd_go = hsel & hready & htrans[1] & ~hwrite;
    assign converter_on = conv_a_r[`ACC_BIT_CONV_EN]; // [R20]

    logic       ctrl_wr;

    assign ctrl_wr = wr_pend_r & (wr_addr_r == `ACC_OFF_CTRL);

    // Bus group: a write is only an address until its data phase follows
    always_comb begin
        wr_pend_nxt = wr_go;
        wr_addr_nxt = wr_go ? haddr[7:0] : wr_addr_r;
        hrdata_nxt  = 32'h0000_0000;
        if (rd_go) begin
            unique case (haddr[7:0])
                `ACC_OFF_CTRL:     hrdata_nxt = {24'h00_0000, ctrl_r[7:6], cmp_sync,
                                                 flag_r, ctrl_r[3:0]}; // [R7]
                `ACC_OFF_CONV_B:   hrdata_nxt = {24'h00_0000, conv_b_r};
                `ACC_OFF_CONV_A:   hrdata_nxt = {24'h00_0000, conv_a_r};
                `ACC_OFF_CHAN_SEL: hrdata_nxt = {29'h0000_0000, chan_r};
                `ACC_OFF_PIN_DIS:  hrdata_nxt = {30'h0000_0000, pin_dis_r}; // [R22]
                default:           hrdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata    <= 32'h0000_0000;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            hrdata    <= hrdata_nxt;
        end
    end

    // Register group: write data lands one cycle after the address phase
    always_comb begin
        ctrl_nxt    = ctrl_r;
        conv_b_nxt  = conv_b_r;
        conv_a_nxt  = conv_a_r;
        chan_nxt    = chan_r;
        pin_dis_nxt = pin_dis_r;
        if (wr_pend_r) begin
            unique case (wr_addr_r)
                // Output and flag bits are never stored from the bus
                `ACC_OFF_CTRL:     ctrl_nxt    = {hwdata[7:6], 2'b00, hwdata[3:0]};
                `ACC_OFF_CONV_B:   conv_b_nxt  = hwdata[7:0]; // [R3]
                `ACC_OFF_CONV_A:   conv_a_nxt  = hwdata[7:0];
                `ACC_OFF_CHAN_SEL: chan_nxt    = hwdata[2:0];
                `ACC_OFF_PIN_DIS:  pin_dis_nxt = hwdata[1:0]; // [R22]
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r    <= `ACC_RST_CTRL;
            conv_b_r  <= `ACC_RST_CONV_B;
            conv_a_r  <= `ACC_RST_CONV_A;
            chan_r    <= `ACC_RST_CHAN_SEL;
            pin_dis_r <= `ACC_RST_PIN_DIS;
        end else begin
            ctrl_r    <= ctrl_nxt;
            conv_b_r  <= conv_b_nxt;
            conv_a_r  <= conv_a_nxt;
            chan_r    <= chan_nxt;
            pin_dis_r <= pin_dis_nxt;
        end
    end

    // Flag group: the set wins over any clear in the same cycle
    always_comb begin
        prev_nxt = cmp_sync;
        flag_nxt = flag_r;
        if (ctrl_wr && hwdata[`ACC_BIT_FLAG]) begin
            flag_nxt = 1'b0; // [R11]
        end
        if (vector_taken) begin
            flag_nxt = 1'b0; // [R10]
        end
        if (evt) begin
            flag_nxt = 1'b1; // [R8]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
            prev_r <= prev_nxt;
        end
    end

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    assign comparator_power_off = ctrl_r[`ACC_BIT_DISABLE]; // [R4]
    assign positive_use_bandgap = ctrl_r[`ACC_BIT_BANDGAP]; // [R6]
    assign negative_use_channel = conv_b_r[`ACC_BIT_MUX_BORROW] & ~converter_on; // [R1] [R2] [R3]
    assign negative_channel     = negative_use_channel ? chan_r : 3'h0; // [R1]
    assign timer_capture_sel    = ctrl_r[`ACC_BIT_CAPTURE]; // [R13]
    // Gated to zero while capture bit 2 is clear so the timer sees no comparator activity
    assign timer_capture_in     = ctrl_r[`ACC_BIT_CAPTURE] & cmp_sync; // [R13] [R14]
    assign comparator_irq       = flag_r & ctrl_r[`ACC_BIT_IE] & global_int_enable; // [R9] [R12]
    assign pin_buffer_enable    = ~pin_dis_r; // [R18]
    assign pin_digital_value    = pin_digital_in & ~pin_dis_r; // [R18]

    sequence s_rise_seen;
        !prev_r ##0 cmp_sync;
    endsequence

    sequence s_fall_seen;
        prev_r ##0 !cmp_sync;
    endsequence

    sequence s_ctrl_write;
        wr_pend_r ##0 (wr_addr_r == `ACC_OFF_CTRL);
    endsequence

    sequence s_raw_rise_held;
        $rose(comparator_raw) ##1 comparator_raw;
    endsequence

    a_flag_on_rise: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
        (mode == acc_pkg::ACC_MODE_RISE) ##0 s_rise_seen |=> flag_r)
        else $error("flag not set on rising edge");

    a_flag_on_fall: assert property (@(posedge hclk) disable iff (!hresetn) // [R16]
        (mode == acc_pkg::ACC_MODE_FALL) ##0 s_fall_seen |=> flag_r)
        else $error("flag not set on falling edge");

    a_rsvd_no_set: assert property (@(posedge hclk) disable iff (!hresetn) // [R21]
        (mode == acc_pkg::ACC_MODE_RSVD && !flag_r) |=> !flag_r)
        else $error("reserved mode set the flag");

    a_fall_event: assert property (@(posedge hclk) disable iff (!hresetn) // [R16]
        (mode == acc_pkg::ACC_MODE_FALL) |-> (evt == $fell(cmp_sync)))
        else $error("falling mode mismatch");

    a_toggle_event: assert property (@(posedge hclk) disable iff (!hresetn) // [R16]
        (mode == acc_pkg::ACC_MODE_TOGGLE) |-> (evt == $changed(cmp_sync)))
        else $error("toggle mode mismatch");

    a_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn) // [R9] [R12]
        comparator_irq |-> (flag_r && ctrl_r[`ACC_BIT_IE] && global_int_enable))
        else $error("interrupt without all enables");

    a_irq_raise: assert property (@(posedge hclk) disable iff (!hresetn) // [R9] [R12]
        (flag_r && ctrl_r[`ACC_BIT_IE] && global_int_enable) |-> comparator_irq)
        else $error("interrupt missing with all enables");

    a_vector_clear: assert property (@(posedge hclk) disable iff (!hresetn) // [R10]
        (vector_taken && !evt) |=> !flag_r)
        else $error("flag survived vector");

    a_w1c_clear: assert property (@(posedge hclk) disable iff (!hresetn) // [R11]
        s_ctrl_write ##0 (hwdata[`ACC_BIT_FLAG] && !evt) |=> !flag_r)
        else $error("flag not cleared by write one");

    a_w0_keep: assert property (@(posedge hclk) disable iff (!hresetn) // [R11]
        s_ctrl_write ##0 (flag_r && !hwdata[`ACC_BIT_FLAG] && !vector_taken) |=> flag_r)
        else $error("flag lost on write zero");

    a_neg_mux: assert property (@(posedge hclk) disable iff (!hresetn) // [R1] [R2]
        negative_use_channel |-> (conv_b_r[`ACC_BIT_MUX_BORROW] && !conv_a_r[`ACC_BIT_CONV_EN]))
        else $error("channel borrowed while converter on");

    a_conv_on_pin: assert property (@(posedge hclk) disable iff (!hresetn) // [R2] [R20]
        (conv_a_r[`ACC_BIT_CONV_EN] || !conv_b_r[`ACC_BIT_MUX_BORROW])
        |-> (!negative_use_channel && negative_channel == 3'h0))
        else $error("negative pin not selected");

    a_chan_range: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
        negative_use_channel |-> (negative_channel == chan_r && negative_channel < CHANNELS))
        else $error("borrowed channel code wrong");

    a_sync_delay: assert property (@(posedge hclk) disable iff (!hresetn) // [R7]
        s_raw_rise_held |=> cmp_sync)
        else $error("synchroniser latency exceeded");

    a_out_bit: assert property (@(posedge hclk) disable iff (!hresetn) // [R7]
        (rd_go && haddr[7:0] == `ACC_OFF_CTRL) |=> (hrdata[`ACC_BIT_OUT] == $past(cmp_sync)))
        else $error("output bit read wrong");

    a_capture_off: assert property (@(posedge hclk) disable iff (!hresetn) // [R14]
        !ctrl_r[`ACC_BIT_CAPTURE] |-> !timer_capture_in)
        else $error("capture path leaks");

    a_capture_on: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
        ctrl_r[`ACC_BIT_CAPTURE] |-> (timer_capture_in == cmp_sync))
        else $error("capture path not following output");

    a_pin_gate: assert property (@(posedge hclk) disable iff (!hresetn) // [R18]
        pin_dis_r[0] |-> (!pin_digital_value[0] && !pin_buffer_enable[0]))
        else $error("disabled positive pin reads nonzero");

    a_pin_gate_neg: assert property (@(posedge hclk) disable iff (!hresetn) // [R18]
        pin_dis_r[1] |-> (!pin_digital_value[1] && !pin_buffer_enable[1]))
        else $error("disabled negative pin reads nonzero");

    a_power_off: assert property (@(posedge hclk) disable iff (!hresetn) // [R4]
        s_ctrl_write |=> (comparator_power_off == $past(hwdata[`ACC_BIT_DISABLE])))
        else $error("disable bit not taken");

    a_bandgap_take: assert property (@(posedge hclk) disable iff (!hresetn) // [R6]
        s_ctrl_write |=> (positive_use_bandgap == $past(hwdata[`ACC_BIT_BANDGAP])))
        else $error("bandgap bit not taken");

    a_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn) // [R22]
        rd_go |=> (hrdata[31:8] == 24'h00_0000))
        else $error("upper read bits nonzero");

    a_pin_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn) // [R22]
        (rd_go && haddr[7:0] == `ACC_OFF_PIN_DIS) |=> (hrdata[7:2] == 6'h00))
        else $error("upper disable bits nonzero");
endmodule // acc_core

// >>> tb/acc_analog_model.sv
/*
 Behavioural analog comparator core with its input pins.
 Assumes bench-driven pin levels in arbitrary 8-bit units.
*/
`timescale 1ns/1ps
module acc_analog_model (
    input  wire logic        comparator_power_off,
    input  wire logic        positive_use_bandgap,
    input  wire logic        negative_use_channel,
    input  wire logic [2:0]  negative_channel,
    input  wire logic [7:0]  pos_lvl,
    input  wire logic [7:0]  neg_lvl,
    input  wire logic [63:0] chan_lvl,
    output logic             comparator_raw
);
    localparam logic [7:0] BANDGAP_LVL = 8'h80;
    logic [7:0] pos_in;
    logic [7:0] neg_in;
    always_comb begin
        pos_in = positive_use_bandgap ? BANDGAP_LVL : pos_lvl;
        neg_in = negative_use_channel ? chan_lvl[8*negative_channel +: 8] : neg_lvl;
        // Unpowered core rests low, so no edges
        comparator_raw = !comparator_power_off && (pos_in > neg_in);
    end
endmodule // acc_analog_model

// >>> tb/comparator_control_logic_test.sv
/*
 Register-level bench for the comparator control logic.
 Assumes zero-wait AHB-Lite slave and the analog model beside it.
*/
`timescale 1ns/1ps
`include "acc_defs.svh"
module comparator_control_logic_test;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rdata;
    logic [1:0]  htrans, pin_digital_in, pin_buffer_enable, pin_digital_value;
    logic [2:0]  hsize, negative_channel;
    logic        comparator_raw, global_int_enable, vector_taken, comparator_power_off;
    logic        positive_use_bandgap, negative_use_channel, timer_capture_in;
    logic        timer_capture_sel, comparator_irq;
    logic [7:0]  pos_lvl, neg_lvl;
    int          fails, n_compared;
    logic [3:0]  fall_exp = 4'b0101;
    logic [3:0]  rise_exp = 4'b1001;
    acc_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .comparator_raw(comparator_raw),
        .global_int_enable(global_int_enable), .vector_taken(vector_taken),
        .pin_digital_in(pin_digital_in), .comparator_power_off(comparator_power_off),
        .positive_use_bandgap(positive_use_bandgap), .negative_use_channel(negative_use_channel),
        .negative_channel(negative_channel), .timer_capture_in(timer_capture_in),
        .timer_capture_sel(timer_capture_sel), .comparator_irq(comparator_irq),
        .pin_buffer_enable(pin_buffer_enable), .pin_digital_value(pin_digital_value));
    acc_analog_model far (.comparator_power_off(comparator_power_off),
        .positive_use_bandgap(positive_use_bandgap), .negative_use_channel(negative_use_channel),
        .negative_channel(negative_channel), .pos_lvl(pos_lvl), .neg_lvl(neg_lvl),
        .chan_lvl(64'h7060504030201000), .comparator_raw(comparator_raw));
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    task automatic report_and_stop;
        if (fails == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Slave may stretch; never assume zero wait
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 50) begin
            fails++;
            report_and_stop();
        end
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rdata = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h00000000);
        chk("reg", rdata, exp);
        chk("hresp", hresp, 32'h0);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    initial begin
        {fails, n_compared} = 0;
        {hsel, hwrite, hresetn, global_int_enable, vector_taken} = 0;
        {haddr, hwdata, htrans} = 0;
        hsize = 3'h2;
        pin_digital_in = 2'h3;
        pos_lvl = 8'h10;
        neg_lvl = 8'h40;
        cyc(12);
        hresetn <= 1'b1;
        rd(`ACC_OFF_CTRL, 32'h00000000);
        rd(`ACC_OFF_PIN_DIS, 32'h00000000);
        rd(8'h20, 32'h00000000);
        xfer(1'b1, `ACC_OFF_PIN_DIS, 32'hFFFFFFFF);
        rd(`ACC_OFF_PIN_DIS, 32'h00000003);
        chk("pin_value", pin_digital_value, 32'h0);
        chk("buf_en", pin_buffer_enable, 32'h0);
        xfer(1'b1, `ACC_OFF_PIN_DIS, 32'h00000001);
        cyc(2);
        chk("pin_value", pin_digital_value, 32'h2);
        xfer(1'b1, `ACC_OFF_CONV_B, 32'h00000040);
        rd(`ACC_OFF_CONV_B, 32'h00000040);
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, `ACC_OFF_CHAN_SEL, i);
            cyc(2);
            chk("use_chan", negative_use_channel, 32'h1);
            chk("chan", negative_channel, i);
        end
        xfer(1'b1, `ACC_OFF_CONV_A, 32'h00000080);
        cyc(2);
        chk("use_chan", negative_use_channel, 32'h0);
        xfer(1'b1, `ACC_OFF_CONV_A, 32'h00000000);
        xfer(1'b1, `ACC_OFF_CONV_B, 32'h00000000);
        cyc(2);
        chk("use_chan", negative_use_channel, 32'h0);
        xfer(1'b1, `ACC_OFF_CTRL, 32'h000000C4);
        cyc(2);
        chk("power_off", comparator_power_off, 32'h1);
        chk("bandgap", positive_use_bandgap, 32'h1);
        // Flag still set by the toggles of the channel sweep
        rd(`ACC_OFF_CTRL, 32'h000000D4);
        xfer(1'b1, `ACC_OFF_CTRL, 32'h00000004);
        pos_lvl <= 8'hF0;
        cyc(3);
        chk("cap_in", timer_capture_in, 32'h1);
        chk("cap_sel", timer_capture_sel, 32'h1);
        rd(`ACC_OFF_CTRL, 32'h00000034);
        xfer(1'b1, `ACC_OFF_CTRL, 32'h00000010);
        cyc(2);
        chk("cap_in", timer_capture_in, 32'h0);
        chk("cap_sel", timer_capture_sel, 32'h0);
        rd(`ACC_OFF_CTRL, 32'h00000020);
        for (int m = 0; m < 4; m++) begin
            xfer(1'b1, `ACC_OFF_CTRL, 32'h10 | m);
            pos_lvl <= 8'h10;
            cyc(4);
            rd(`ACC_OFF_CTRL, (fall_exp[m] << 4) | m);
            xfer(1'b1, `ACC_OFF_CTRL, 32'h10 | m);
            pos_lvl <= 8'hF0;
            cyc(4);
            rd(`ACC_OFF_CTRL, 32'h20 | (rise_exp[m] << 4) | m);
        end
        xfer(1'b1, `ACC_OFF_CTRL, 32'h0000000B);
        rd(`ACC_OFF_CTRL, 32'h0000003B);
        global_int_enable <= 1'b1;
        cyc(2);
        chk("irq", comparator_irq, 32'h1);
        global_int_enable <= 1'b0;
        cyc(2);
        chk("irq", comparator_irq, 32'h0);
        global_int_enable <= 1'b1;
        xfer(1'b1, `ACC_OFF_CTRL, 32'h00000003);
        cyc(2);
        chk("irq", comparator_irq, 32'h0);
        vector_taken <= 1'b1;
        cyc(1);
        vector_taken <= 1'b0;
        cyc(1);
        rd(`ACC_OFF_CTRL, 32'h00000023);
        report_and_stop();
    end
endmodule // comparator_control_logic_test
